// file: eeprom_pkg.sv
// Shared constants and types of the serial memory slave
package eeprom_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Addressing and array layout
   localparam int          MAX_ADDR_BITS = 11;
   localparam int          MIN_ADDR_BITS = 8;
   localparam int          PAGE_IDX_BITS = 4;
   localparam int          PAGE_BYTES    = 16;
   localparam int          DEV_BIT_COUNT = 3;
   localparam logic [3:0]  DEVICE_PREFIX = 4'ha;
   localparam logic [7:0]  ERASED_BYTE   = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Bit framing and page commit sequence
   localparam logic [3:0]  BIT_LAST      = 4'h8;
   localparam logic [4:0]  COMMIT_END    = 5'h11;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int          CLK_PERIOD_NS           = 4;
   localparam int          PROGRAM_CYCLE_TIME_MS   = 5;
   localparam int          BUSY_CNT_BITS           = 21;
   localparam logic [20:0] PROGRAM_CYCLES_DEF      =
      21'((PROGRAM_CYCLE_TIME_MS * 1000000) / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchroniser: {strap2, strap1, strap0, wp, sda, scl}
   localparam int          SYNC_WIDTH    = 6;
   localparam logic [5:0]  SYNC_RESET    = 6'h03;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [10:0] PTR_RESET     = 11'h000;
   localparam logic [7:0]  SHIFT_RESET   = 8'h00;
   localparam logic [3:0]  CNT_RESET     = 4'h0;
   localparam logic [15:0] VALID_RESET   = 16'h0000;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_ACK_ADDR  = 4'h2,
      ST_WORD      = 4'h3,
      ST_ACK_WORD  = 4'h4,
      ST_WDATA     = 4'h5,
      ST_ACK_WDATA = 4'h6,
      ST_RDATA     = 4'h7,
      ST_RACK      = 4'h8
   } link_state_t;

endpackage

// file: pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync
#(
   parameter int                WIDTH     = 1,
   parameter logic [WIDTH-1:0]  RESET_VAL = '0
)
(
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   // Pins in, filtered levels out
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_dout;

   ////////////////////////////////////////////////////////////////////////////
   // A bit moves only once the last two stages agree
   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         next_dout[i] = (stage2[i] == stage3[i]) ? stage3[i] : dout[i];
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage1 <= RESET_VAL;
         stage2 <= RESET_VAL;
         stage3 <= RESET_VAL;
         dout   <= RESET_VAL;
      end
      else
      begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         dout   <= next_dout;
      end
   end

endmodule

// file: mem_array.sv
// Byte memory with one write port and a registered read port
`timescale 1ns/100ps
module mem_array
#(
   parameter int         ADDR_W = 4,
   parameter logic [7:0] FILL   = 8'h00
)
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   // Write port
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [7:0]        wr_data,
   // Read port
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [7:0]        rd_data
);

   logic [7:0] cells [0:(1 << ADDR_W)-1];

   ////////////////////////////////////////////////////////////////////////////
   // Never-written cells hold the fill value
   initial
   begin
      for (int i = 0; i < (1 << ADDR_W); i++)
      begin
         cells[i] = FILL;
      end
   end

   // Plain always: the fill loop above also writes the cells
   always @(posedge clk_sys)
   begin
      if (wr_en)
      begin
         cells[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rd_data <= 8'h00;
      end
      else
      begin
         rd_data <= cells[rd_addr];
      end
   end

endmodule

// file: i2c_serial_eeprom_slave.sv
// Two-wire serial memory slave: framing, page buffer, programming timer
`timescale 1ns/100ps
module i2c_serial_eeprom_slave
#(
   parameter int                                     MEM_ADDR_BITS  = 8,
   parameter logic [eeprom_pkg::BUSY_CNT_BITS-1:0]   PROGRAM_CYCLES =
      eeprom_pkg::PROGRAM_CYCLES_DEF
)
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic arst_n,
   // Serial bus
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   // Straps and protection
   input  wire logic chip_select_strap_0,
   input  wire logic chip_select_strap_1,
   input  wire logic chip_select_strap_2,
   input  wire logic write_protect,
   // Status
   output logic      program_busy
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [10:0] mem_mask();
      mem_mask = 11'((1 << MEM_ADDR_BITS) - 1);
   endfunction

   function automatic logic addr_match(input logic [2:0] bits, input logic [2:0] straps);
      addr_match = 1'b1;
      for (int i = 0; i < eeprom_pkg::DEV_BIT_COUNT; i++)
      begin
         if ((i >= MEM_ADDR_BITS - eeprom_pkg::MIN_ADDR_BITS) && (bits[i] != straps[i]))
         begin
            addr_match = 1'b0;
         end
      end
   endfunction

   function automatic logic [10:0] addr_join(input logic [2:0] upper, input logic [7:0] low);
      addr_join = {upper, low} & mem_mask();
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Input conditioning and bus events

   logic [5:0] pins_raw;
   logic [5:0] pins;
   logic       scl;
   logic       sda;
   logic       wp;
   logic [2:0] strap;
   logic       scl_d;
   logic       sda_d;

   assign pins_raw = {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0,
                      write_protect, sda_in, scl_in};
   assign scl      = pins[0];
   assign sda      = pins[1];
   assign wp       = pins[2];
   assign strap    = pins[5:3];

   pin_sync
   #(
      .WIDTH     (eeprom_pkg::SYNC_WIDTH),
      .RESET_VAL (eeprom_pkg::SYNC_RESET)
   )
   u_sync
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .din     (pins_raw),
      .dout    (pins)
   );

   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic scl_fall;

   assign start_det = scl && scl_d && sda_d && !sda;
   assign stop_det  = scl && scl_d && !sda_d && sda;
   assign scl_rise  = scl && !scl_d;
   assign scl_fall  = !scl && scl_d;

   ////////////////////////////////////////////////////////////////////////////
   // Protocol state

   eeprom_pkg::link_state_t state;
   eeprom_pkg::link_state_t next_state;
   logic [3:0]  bit_cnt;
   logic [3:0]  next_bit_cnt;
   logic [7:0]  shreg;
   logic [7:0]  next_shreg;
   logic [10:0] ptr;
   logic [10:0] next_ptr;
   logic [2:0]  upper;
   logic [2:0]  next_upper;
   logic        dir_read;
   logic        next_dir_read;
   logic        wp_flag;
   logic        next_wp_flag;
   logic        master_ack;
   logic        next_master_ack;
   logic        drive;
   logic        next_drive;
   logic [15:0] valid;
   logic [15:0] next_valid;
   logic        buf_we;
   logic [7:0]  mem_rdata;
   logic [7:0]  buf_rdata;
   logic        busy;
   logic        write_pending;

   assign write_pending = ((state == eeprom_pkg::ST_WDATA) ||
                           (state == eeprom_pkg::ST_ACK_WDATA)) &&
                          (valid != eeprom_pkg::VALID_RESET) && !wp_flag;

   always_comb
   begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_shreg      = shreg;
      next_ptr        = ptr;
      next_upper      = upper;
      next_dir_read   = dir_read;
      next_wp_flag    = wp_flag;
      next_master_ack = master_ack;
      next_drive      = drive;
      next_valid      = valid;
      buf_we          = 1'b0;
      if (busy)
      begin
         // Deaf while programming, so polling sees no acknowledge
         next_state = eeprom_pkg::ST_IDLE;
         next_drive = 1'b0;
      end
      else if (start_det)
      begin
         // Repeated START abandons any unfinished page
         next_state   = eeprom_pkg::ST_ADDR;
         next_bit_cnt = eeprom_pkg::CNT_RESET;
         next_drive   = 1'b0;
         next_valid   = eeprom_pkg::VALID_RESET;
      end
      else if (stop_det)
      begin
         next_state = eeprom_pkg::ST_IDLE;
         next_drive = 1'b0;
      end
      else
      begin
         case (state)
            eeprom_pkg::ST_ADDR, eeprom_pkg::ST_WORD, eeprom_pkg::ST_WDATA:
            begin
               if (scl_rise)
               begin
                  next_shreg   = {shreg[6:0], sda};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               else if (scl_fall && (bit_cnt == eeprom_pkg::BIT_LAST))
               begin
                  next_bit_cnt = eeprom_pkg::CNT_RESET;
                  if (state == eeprom_pkg::ST_ADDR)
                  begin
                     if ((shreg[7:4] == eeprom_pkg::DEVICE_PREFIX) &&
                         addr_match(shreg[3:1], strap))
                     begin
                        next_drive    = 1'b1;
                        next_dir_read = shreg[0];
                        next_upper    = shreg[3:1];
                        next_state    = eeprom_pkg::ST_ACK_ADDR;
                     end
                     else
                     begin
                        next_state = eeprom_pkg::ST_IDLE;
                     end
                  end
                  else if (state == eeprom_pkg::ST_WORD)
                  begin
                     next_drive = 1'b1;
                     next_ptr   = addr_join(upper, shreg);
                     next_state = eeprom_pkg::ST_ACK_WORD;
                  end
                  else if (wp_flag)
                  begin
                     next_valid = eeprom_pkg::VALID_RESET;
                     next_state = eeprom_pkg::ST_IDLE;
                  end
                  else
                  begin
                     next_drive           = 1'b1;
                     buf_we               = 1'b1;
                     next_valid[ptr[3:0]] = 1'b1;
                     next_ptr[3:0]        = ptr[3:0] + 4'h1;
                     next_state           = eeprom_pkg::ST_ACK_WDATA;
                  end
               end
            end
            eeprom_pkg::ST_ACK_ADDR:
            begin
               if (scl_fall)
               begin
                  if (dir_read)
                  begin
                     // Read from the current pointer
                     next_shreg   = mem_rdata;
                     next_drive   = !mem_rdata[7];
                     next_bit_cnt = eeprom_pkg::CNT_RESET;
                     next_state   = eeprom_pkg::ST_RDATA;
                  end
                  else
                  begin
                     next_drive = 1'b0;
                     next_state = eeprom_pkg::ST_WORD;
                  end
               end
            end
            eeprom_pkg::ST_ACK_WORD:
            begin
               if (scl_fall)
               begin
                  next_drive   = 1'b0;
                  next_wp_flag = wp;
                  next_state   = eeprom_pkg::ST_WDATA;
               end
            end
            eeprom_pkg::ST_ACK_WDATA:
            begin
               if (scl_fall)
               begin
                  next_drive = 1'b0;
                  next_state = eeprom_pkg::ST_WDATA;
               end
            end
            eeprom_pkg::ST_RDATA:
            begin
               if (scl_rise)
               begin
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               else if (scl_fall)
               begin
                  if (bit_cnt == eeprom_pkg::BIT_LAST)
                  begin
                     next_drive   = 1'b0;
                     next_bit_cnt = eeprom_pkg::CNT_RESET;
                     next_ptr     = (ptr + 11'h001) & mem_mask();
                     next_state   = eeprom_pkg::ST_RACK;
                  end
                  else
                  begin
                     next_drive = !shreg[6];
                     next_shreg = {shreg[6:0], 1'b0};
                  end
               end
            end
            eeprom_pkg::ST_RACK:
            begin
               if (scl_rise)
               begin
                  next_master_ack = !sda;
               end
               else if (scl_fall)
               begin
                  if (master_ack)
                  begin
                     // Pointer moved many cycles ago, read data is settled
                     next_shreg = mem_rdata;
                     next_drive = !mem_rdata[7];
                     next_state = eeprom_pkg::ST_RDATA;
                  end
                  else
                  begin
                     next_state = eeprom_pkg::ST_IDLE;
                  end
               end
            end
            default:
            begin
               next_state = eeprom_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state      <= eeprom_pkg::ST_IDLE;
         bit_cnt    <= eeprom_pkg::CNT_RESET;
         shreg      <= eeprom_pkg::SHIFT_RESET;
         ptr        <= eeprom_pkg::PTR_RESET;
         upper      <= 3'h0;
         dir_read   <= 1'b0;
         wp_flag    <= 1'b0;
         master_ack <= 1'b0;
         drive      <= 1'b0;
         valid      <= eeprom_pkg::VALID_RESET;
         scl_d      <= 1'b1;
         sda_d      <= 1'b1;
         sda_out    <= 1'b0;
         sda_oe     <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         shreg      <= next_shreg;
         ptr        <= next_ptr;
         upper      <= next_upper;
         dir_read   <= next_dir_read;
         wp_flag    <= next_wp_flag;
         master_ack <= next_master_ack;
         drive      <= next_drive;
         valid      <= next_valid;
         scl_d      <= scl;
         sda_d      <= sda;
         sda_out    <= 1'b0;
         sda_oe     <= next_drive;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Programming timer and page commit

   logic [20:0] prog_cnt;
   logic [20:0] next_prog_cnt;
   logic [4:0]  commit;
   logic [4:0]  next_commit;
   logic        next_busy;
   logic [3:0]  commit_idx;
   logic        mem_we;
   logic [10:0] mem_waddr;

   assign commit_idx = 4'(commit - 5'h01);
   assign mem_we     = busy && (commit != 5'h00) && (commit != eeprom_pkg::COMMIT_END) &&
                       valid[commit_idx];
   assign mem_waddr  = {ptr[10:4], commit_idx};

   always_comb
   begin
      next_busy     = busy;
      next_prog_cnt = prog_cnt;
      next_commit   = commit;
      if (!busy)
      begin
         if (stop_det && write_pending)
         begin
            next_busy     = 1'b1;
            next_prog_cnt = PROGRAM_CYCLES;
            next_commit   = 5'h00;
         end
      end
      else
      begin
         if (commit != eeprom_pkg::COMMIT_END)
         begin
            next_commit = commit + 5'h01;
         end
         if (prog_cnt <= 21'h000001)
         begin
            next_busy = 1'b0;
         end
         next_prog_cnt = prog_cnt - 21'h000001;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy         <= 1'b0;
         prog_cnt     <= 21'h000000;
         commit       <= 5'h00;
         program_busy <= 1'b0;
      end
      else
      begin
         busy         <= next_busy;
         prog_cnt     <= next_prog_cnt;
         commit       <= next_commit;
         program_busy <= next_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Storage: page buffer feeds the array only at commit time

   mem_array
   #(
      .ADDR_W (eeprom_pkg::PAGE_IDX_BITS),
      .FILL   (eeprom_pkg::ERASED_BYTE)
   )
   u_page_buf
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .wr_en   (buf_we),
      .wr_addr (ptr[3:0]),
      .wr_data (shreg),
      .rd_addr (commit[3:0]),
      .rd_data (buf_rdata)
   );

   mem_array
   #(
      .ADDR_W (eeprom_pkg::MAX_ADDR_BITS),
      .FILL   (eeprom_pkg::ERASED_BYTE)
   )
   u_array
   (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .wr_en   (mem_we),
      .wr_addr (mem_waddr),
      .wr_data (buf_rdata),
      .rd_addr (ptr),
      .rd_data (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence byte_end_s(eeprom_pkg::link_state_t st);
      (state == st) && !busy && !start_det && !stop_det && scl_fall &&
      (bit_cnt == eeprom_pkg::BIT_LAST);
   endsequence

   sequence page_store_s;
      buf_we && !busy;
   endsequence

   AST_BUSY_FLOAT: assert property (busy |=> !sda_oe)
      else $error("data line driven while programming");

   AST_START_ADDR: assert property (start_det && !busy |=> state == eeprom_pkg::ST_ADDR)
      else $error("start not taken");

   AST_IDLE_QUIET: assert property ((state == eeprom_pkg::ST_IDLE) && !start_det
      |=> !sda_oe)
      else $error("driving while idle");

   AST_ADDR_ACK: assert property (byte_end_s(eeprom_pkg::ST_ADDR) ##0
      ((shreg[7:4] == eeprom_pkg::DEVICE_PREFIX) && addr_match(shreg[3:1], strap))
      |=> sda_oe && (state == eeprom_pkg::ST_ACK_ADDR))
      else $error("matching address not acknowledged");

   AST_PREFIX_REJECT: assert property (byte_end_s(eeprom_pkg::ST_ADDR) ##0
      (shreg[7:4] != eeprom_pkg::DEVICE_PREFIX)
      |=> !sda_oe && (state == eeprom_pkg::ST_IDLE))
      else $error("foreign address answered");

   AST_WP_REFUSE: assert property (byte_end_s(eeprom_pkg::ST_WDATA) ##0 wp_flag
      |=> !sda_oe ##1 !busy)
      else $error("protected byte accepted");

   AST_PAGE_STAY: assert property (page_store_s |=> (ptr[10:4] == $past(ptr[10:4])) &&
      (ptr[3:0] == 4'($past(ptr[3:0]) + 4'h1)))
      else $error("page bits moved on write");

   AST_READ_STEP: assert property (byte_end_s(eeprom_pkg::ST_RDATA)
      |=> !sda_oe && (state == eeprom_pkg::ST_RACK) &&
      (ptr == ((11'($past(ptr)) + 11'h001) & mem_mask())))
      else $error("read pointer or release wrong");

   AST_PROG_START: assert property (stop_det && write_pending && !busy
      |=> busy [*2])
      else $error("programming not started at stop");

   AST_BUSY_ENDS: assert property ($fell(busy) |-> $past(prog_cnt) <= 21'h000001)
      else $error("busy ended early");

endmodule

// file: i2c_master_model.sv
// Behavioural two-wire bus master for the memory slave bench
`timescale 1ns/100ps
module i2c_master_model
(
   // Clock
   input  wire logic clk_sys,
   // Bus
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_low
);
   initial scl = 1'b1;
   initial sda_low = 1'b0;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Only called with the bus idle or mid-frame
   task automatic start;
      sda_low <= 1'b0;
      tick(5);
      scl <= 1'b1;
      tick(10);
      sda_low <= 1'b1;
      tick(10);
      scl <= 1'b0;
      tick(5);
   endtask
   task automatic stop;
      sda_low <= 1'b1;
      tick(5);
      scl <= 1'b1;
      tick(10);
      sda_low <= 1'b0;
      tick(20);
   endtask
   // Data moves only with the clock low
   task automatic bit_cycle(input logic b, output logic r);
      sda_low <= ~b;
      tick(5);
      scl <= 1'b1;
      tick(5);
      r = sda_line;
      tick(5);
      scl <= 1'b0;
      tick(5);
   endtask
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_cycle(b[i], r);
      bit_cycle(1'b1, ack);
      ack = ~ack;
   endtask
   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 0; i < 8; i++)
      begin
         bit_cycle(1'b1, r);
         d = {d[6:0], r};
      end
      bit_cycle(~more, r);
   endtask
endmodule

// file: tb.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/100ps
module tb;
   typedef struct packed {logic [8:0] a; logic [7:0] v;} row_t;
   logic       clk_sys = 1'b0;
   logic       arst_n = 1'b0;
   logic       wp, strap_1, strap_2, scl, m_low, sda_out, sda_oe, busy, ack;
   logic [7:0] d;
   int         fails = 0;
   int         compares = 0;
   int         k;
   row_t       rows [4] = '{'{9'h000, 8'h5a}, '{9'h001, 8'ha5}, '{9'h0ff, 8'h3c},
                            '{9'h1fe, 8'hc3}};
   wire logic  sda_line = ~(m_low | sda_oe);
   always #2 clk_sys = ~clk_sys;
   i2c_serial_eeprom_slave #(.MEM_ADDR_BITS(9), .PROGRAM_CYCLES(21'h0000c8)) i_dut (
      .clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_strap_0(1'b1),
      .chip_select_strap_1(strap_1), .chip_select_strap_2(strap_2),
      .write_protect(wp), .program_busy(busy));
   i2c_master_model i_mst (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(m_low));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic req(input logic [7:0] b, input logic exp);
      i_mst.wr_byte(b, ack);
      chk("ack", {7'h00, exp}, {7'h00, ack});
   endtask
   // Dummy write loads the pointer, then optional turn to reading
   task automatic sel(input logic [8:0] a, input logic rd);
      i_mst.start();
      req({6'h29, a[8], 1'b0}, 1'b1);
      req(a[7:0], 1'b1);
      if (rd)
      begin
         i_mst.start();
         req({6'h29, a[8], 1'b1}, 1'b1);
      end
   endtask
   task automatic probe(input logic [7:0] b, input logic exp);
      i_mst.start();
      req(b, exp);
      i_mst.stop();
   endtask
   task automatic poll;
      ack = 1'b0;
      for (int n = 0; n < 10 && ack !== 1'b1; n++)
      begin
         i_mst.start();
         i_mst.wr_byte(8'ha4, ack);
         i_mst.stop();
      end
      if (ack !== 1'b1)
      begin
         fails++;
         final_report();
      end
   endtask
   task automatic final_report;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      wp <= 1'b0;
      strap_1 <= 1'b1;
      strap_2 <= 1'b0;
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (20) @(posedge clk_sys);
      sel(9'h055, 1'b1);
      i_mst.rd_byte(1'b0, d);
      chk("erased", 8'hff, d);
      i_mst.stop();
      foreach (rows[i])
      begin
         sel(rows[i].a, 1'b0);
         req(rows[i].v, 1'b1);
         i_mst.stop();
         poll();
         sel(rows[i].a, 1'b1);
         i_mst.rd_byte(1'b0, d);
         chk("readback", rows[i].v, d);
         i_mst.stop();
      end
      probe(8'hb4, 1'b0);
      probe(8'hac, 1'b0);
      strap_1 <= 1'b0;
      repeat (8) @(posedge clk_sys);
      probe(8'ha0, 1'b1);
      probe(8'ha4, 1'b0);
      strap_1 <= 1'b1;
      sel(9'h1e3, 1'b0);
      for (int i = 0; i < 18; i++)
         req(8'h40 + 8'(i), 1'b1);
      i_mst.stop();
      chk("busy", 8'h01, {7'h00, busy});
      probe(8'ha4, 1'b0);
      poll();
      sel(9'h1e0, 1'b1);
      for (int p = 0; p < 16; p++)
      begin
         k = (p + 13) % 16;
         k = (k < 2) ? k + 16 : k;
         i_mst.rd_byte(p < 15, d);
         chk("page", 8'h40 + 8'(k), d);
      end
      i_mst.stop();
      sel(9'h1ff, 1'b1);
      i_mst.rd_byte(1'b1, d);
      chk("last", 8'hff, d);
      i_mst.rd_byte(1'b0, d);
      chk("wrap", rows[0].v, d);
      i_mst.stop();
      probe(8'ha5, 1'b1);
      i_mst.start();
      req(8'ha5, 1'b1);
      i_mst.rd_byte(1'b0, d);
      chk("current", rows[1].v, d);
      i_mst.stop();
      wp <= 1'b1;
      sel(9'h010, 1'b0);
      req(8'h33, 1'b0);
      i_mst.stop();
      chk("wp_busy", 8'h00, {7'h00, busy});
      wp <= 1'b0;
      sel(9'h010, 1'b1);
      i_mst.rd_byte(1'b0, d);
      chk("protected", 8'hff, d);
      i_mst.stop();
      // Repeated START after a data byte abandons the page
      sel(9'h021, 1'b0);
      req(8'h77, 1'b1);
      i_mst.start();
      req(8'ha5, 1'b1);
      i_mst.rd_byte(1'b0, d);
      chk("current_rs", 8'hff, d);
      i_mst.stop();
      chk("rs_busy", 8'h00, {7'h00, busy});
      // Mid-run reset while programming: busy clears, array keeps contents
      sel(9'h020, 1'b0);
      req(8'h96, 1'b1);
      i_mst.stop();
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      chk("rst_busy", 8'h00, {7'h00, busy});
      chk("rst_oe", 8'h00, {7'h00, sda_oe});
      arst_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
      sel(9'h020, 1'b1);
      i_mst.rd_byte(1'b1, d);
      chk("kept", 8'h96, d);
      i_mst.rd_byte(1'b0, d);
      chk("dropped", 8'hff, d);
      i_mst.stop();
      chk("sda_out", 8'h00, {7'h00, sda_out});
      final_report();
   end
endmodule
